// ### common/ccr_regs.svh
// Register map, field positions, reset values and link timing for the codec control register bank.
// Assumes inclusion by bare name from the device, host and bench modules.
`ifndef CCR_REGS_SVH
`define CCR_REGS_SVH
`define CCR_ADDR_NOP        5'h00
`define CCR_ADDR_CTRL1      5'h01
`define CCR_ADDR_CTRL2      5'h02
`define CCR_ADDR_CTRL3      5'h03
`define CCR_ADDR_CTRL4      5'h04
`define CCR_RW_BIT          13
`define CCR_ADDR_HI         12
`define CCR_ADDR_LO         8
`define CCR_DATA_HI         7
`define CCR_C1_SWRESET      7
`define CCR_C1_PWRDN        6
`define CCR_C1_ADC_AUX      5
`define CCR_C1_MON_AUX      4
`define CCR_C1_DLOOP        1
`define CCR_C1_DAC16        0
`define CCR_C2_FLAG         7
`define CCR_C2_PHONE        6
`define CCR_C2_OVF          5
`define CCR_C2_ADC16        4
`define CCR_C2_ALOOP        3
`define CCR_C2_SYNC_DLY_DIS 2
`define CCR_C4_PLL_BYP      7
`define CCR_RESET_VAL       8'h00
`define CCR_SYNC_DLY_MIN    6'h12
`define CCR_WORD_BITS       16
`define CCR_HOST_DIV        4
`define CCR_APB_CMD         12'h000
`define CCR_APB_STAT        12'h004
`define CCR_APB_RDATA       12'h008
`endif

// ### common/ccr_pkg.sv
// Types for the codec control link: monitor gain at the register bank, state of the host port.
// Assumes ccr_regs.svh on the include path.
package ccr_pkg;
  typedef enum logic [1:0] {
    CCR_MON_MUTE = 2'b00,
    CCR_MON_0DB  = 2'b01,
    CCR_MON_M8DB = 2'b10,
    CCR_MON_M18  = 2'b11
  } ccr_mon_gain_t;
  typedef enum logic [1:0] {
    CCR_H_IDLE  = 2'b00,
    CCR_H_SHIFT = 2'b01,
    CCR_H_DONE  = 2'b10
  } ccr_host_state_t;
endpackage

// ### common/ccr_link_if.sv
// Serial control link between host port and codec register bank.
// Assumes one system clock; the host makes bit clock and frame strobe.
`timescale 1ns/1ns
interface ccr_link_if;
  logic bit_clk;
  logic frame_sync_in;
  logic host_dout;
  logic dev_dout;
  modport host (output bit_clk, output frame_sync_in, output host_dout, input dev_dout);
  modport dev  (input bit_clk, input frame_sync_in, input host_dout, output dev_dout);
endinterface

// ### src/ccr_device.sv
// Codec control register bank: decodes secondary serial words and holds four control registers.
// Assumes link pins from another chip; each passes two flip-flops before use.
`timescale 1ns/1ns
`include "ccr_regs.svh"
// Functional notes
// - Bits 12..8 address, bits 7..0 data
// - Bit 13 low writes, high reads
// - Address 0 no-op, 1..4 control registers
// - Reset bit pulses once then self-clears
// - Register 1 bit 6 powers down analog
// - Register 1 bit 5 picks ADC input
// - Register 1 bit 4 picks monitor input
// - Register 1 bits 3:2 monitor gain
// - Bit 1 digital loopback, bit 0 DAC16
// - Bit 0 low: 15+1 DAC, software requests
// - Register 2 bit 5 overflow, read only
// - Register 2 bit 4 selects ADC16
// - Flag pin, phone, analog loopback, delayed sync disable
// - Register 3 bits 5:0 sync delay, min 18
// - Register 3 bits 7:6 slave count
// - Register 4 bits 3:2 input gain
// - Register 4 bits 1:0 output gain
// - Register 4 bits 6:4 divisor, 0 means 8
// - Register 4 bit 7 bypasses phase loop
// - Host programs 1, 2, 4, then 3
// - After register 3 write, use time slot
// - Host writes zeros to reserved bits; the host port forces only bits 15:14 low
module ccr_device (
  // System.
  input  wire logic       clk,
  input  wire logic       rst,
  // Serial link.
  ccr_link_if.dev         link,
  // Codec core status.
  input  wire logic       fir_overflow,
  // Decoded controls.
  output logic            soft_reset,
  output logic            power_down,
  output logic            adc_aux_sel,
  output logic            mon_aux_sel,
  output ccr_pkg::ccr_mon_gain_t mon_gain,
  output logic            digital_loopback,
  output logic            dac_16bit,
  output logic            sw_secondary_req,
  output logic            flag_out,
  output logic            phone_mode,
  output logic            adc_16bit,
  output logic            analog_loopback,
  output logic            sync_delay_en,
  output logic [5:0]      sync_delay_bits,
  output logic            sync_delay_low,
  output logic [1:0]      slave_count,
  output logic [1:0]      in_gain,
  output logic [1:0]      out_gain,
  output logic [3:0]      rate_divisor,
  output logic            pll_bypass,
  output logic            slot_active
);
  typedef struct packed {
    logic [1:0]  clk_s;
    logic [1:0]  fsync_s;
    logic [1:0]  din_s;
    logic        clk_d;
    logic        in_frame;
    logic [4:0]  cnt;
    logic [15:0] shin;
    logic [15:0] shout;
    logic [7:0]  c1;
    logic [7:0]  c2;
    logic [7:0]  c3;
    logic [7:0]  c4;
    logic        rst_pulse;
    logic        slot;
    logic        ovf;
  } ccr_dev_state_t;
  ccr_dev_state_t s_reg;
  ccr_dev_state_t s_next;
  logic           rise;
  logic [15:0]    word;
  logic [7:0]     rd;

  function automatic logic [7:0] ccr_read(input logic [4:0] a, input ccr_dev_state_t s);
    if (a == `CCR_ADDR_CTRL1) begin
      ccr_read = s.c1;
    end else if (a == `CCR_ADDR_CTRL2) begin
      ccr_read = s.c2 | (8'h01 << `CCR_C2_OVF) & {8{s.ovf}};
    end else if (a == `CCR_ADDR_CTRL3) begin
      ccr_read = s.c3;
    end else if (a == `CCR_ADDR_CTRL4) begin
      ccr_read = s.c4;
    end else begin
      ccr_read = 8'h00;
    end
  endfunction

  always_comb begin
    s_next = s_reg;
    s_next.clk_s = {s_reg.clk_s[0], link.bit_clk};
    s_next.fsync_s = {s_reg.fsync_s[0], link.frame_sync_in};
    s_next.din_s = {s_reg.din_s[0], link.host_dout};
    s_next.clk_d = s_reg.clk_s[1];
    s_next.rst_pulse = 1'b0;
    s_next.ovf = s_reg.ovf | fir_overflow;
    rise = s_reg.clk_s[1] & ~s_reg.clk_d;
    word = {s_reg.shin[14:0], s_reg.din_s[1]};
    rd = 8'h00;
    if (rise) begin
      if (!s_reg.in_frame && s_reg.fsync_s[1]) begin
        s_next.in_frame = 1'b1;
        s_next.cnt = 5'h01;
        s_next.shin = {15'h0000, s_reg.din_s[1]};
        s_next.shout = {s_reg.shout[14:0], 1'b0};
      end else if (s_reg.in_frame) begin
        s_next.shin = word;
        s_next.shout = {s_reg.shout[14:0], 1'b0};
        s_next.cnt = s_reg.cnt + 5'h01;
        if (s_reg.cnt == 5'h0F) begin
          s_next.in_frame = 1'b0;
          if (word[`CCR_RW_BIT]) begin
            rd = ccr_read(word[`CCR_ADDR_HI:`CCR_ADDR_LO], s_reg);
            s_next.shout = {word[15:8], rd};
            if (word[`CCR_ADDR_HI:`CCR_ADDR_LO] == `CCR_ADDR_CTRL2) begin
              s_next.ovf = fir_overflow;
            end
          end else if (word[`CCR_ADDR_HI:`CCR_ADDR_LO] == `CCR_ADDR_CTRL1) begin
            s_next.c1 = word[`CCR_DATA_HI:0] & ~(8'h01 << `CCR_C1_SWRESET);
            s_next.rst_pulse = word[`CCR_C1_SWRESET];
          end else if (word[`CCR_ADDR_HI:`CCR_ADDR_LO] == `CCR_ADDR_CTRL2) begin
            s_next.c2 = word[`CCR_DATA_HI:0] & ~(8'h01 << `CCR_C2_OVF);
          end else if (word[`CCR_ADDR_HI:`CCR_ADDR_LO] == `CCR_ADDR_CTRL3) begin
            s_next.c3 = word[`CCR_DATA_HI:0];
            s_next.slot = 1'b1;
          end else if (word[`CCR_ADDR_HI:`CCR_ADDR_LO] == `CCR_ADDR_CTRL4) begin
            s_next.c4 = word[`CCR_DATA_HI:0];
          end
        end
      end
    end
    // A software reset restores registers 2, 3 and 4, and it also drops the time slot.
    if (s_reg.rst_pulse) begin
      s_next.c2 = `CCR_RESET_VAL;
      s_next.c3 = `CCR_RESET_VAL;
      s_next.c4 = `CCR_RESET_VAL;
      s_next.slot = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign link.dev_dout = s_reg.shout[15];
  assign soft_reset = s_reg.rst_pulse;
  assign power_down = s_reg.c1[`CCR_C1_PWRDN];
  assign adc_aux_sel = s_reg.c1[`CCR_C1_ADC_AUX];
  assign mon_aux_sel = s_reg.c1[`CCR_C1_MON_AUX];
  assign mon_gain = ccr_pkg::ccr_mon_gain_t'(s_reg.c1[3:2]);
  assign digital_loopback = s_reg.c1[`CCR_C1_DLOOP];
  assign dac_16bit = s_reg.c1[`CCR_C1_DAC16];
  assign sw_secondary_req = ~s_reg.c1[`CCR_C1_DAC16];
  assign flag_out = s_reg.c2[`CCR_C2_FLAG];
  assign phone_mode = s_reg.c2[`CCR_C2_PHONE];
  assign adc_16bit = s_reg.c2[`CCR_C2_ADC16];
  assign analog_loopback = s_reg.c2[`CCR_C2_ALOOP];
  assign sync_delay_en = ~s_reg.c2[`CCR_C2_SYNC_DLY_DIS];
  assign sync_delay_bits = s_reg.c3[5:0];
  // The device cannot refuse a short spacing; it only flags it for the core.
  assign sync_delay_low = s_reg.slot && (s_reg.c3[5:0] < `CCR_SYNC_DLY_MIN);
  assign slave_count = s_reg.c3[7:6];
  assign in_gain = s_reg.c4[3:2];
  assign out_gain = s_reg.c4[1:0];
  assign rate_divisor = (s_reg.c4[6:4] == 3'h0) ? 4'h8 : {1'b0, s_reg.c4[6:4]};
  assign pll_bypass = s_reg.c4[`CCR_C4_PLL_BYP];
  assign slot_active = s_reg.slot;
endmodule

// ### src/ccr_host.sv
// Host serial port: APB slave registers drive secondary control words onto the codec link.
// Assumes the device end samples the link through its own synchronisers.
`timescale 1ns/1ns
`include "ccr_regs.svh"
module ccr_host (
  // System.
  input  wire logic        clk,
  input  wire logic        rst,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial link.
  ccr_link_if.host         link
);
  typedef struct packed {
    ccr_pkg::ccr_host_state_t st;
    logic [3:0]  div;
    logic        sclk;
    logic [4:0]  bits;
    logic [15:0] shout;
    logic [15:0] shin;
    logic [1:0]  din_s;
    logic        fsync;
    logic [7:0]  rdata;
    logic        done;
    logic [31:0] prdata;
  } ccr_host_state_s_t;
  ccr_host_state_s_t h_reg;
  ccr_host_state_s_t h_next;
  logic              acc;
  logic              tick;

  always_comb begin
    h_next = h_reg;
    h_next.din_s = {h_reg.din_s[0], link.dev_dout};
    acc = psel & penable;
    tick = (h_reg.div == 4'(`CCR_HOST_DIV - 1));
    h_next.div = tick ? 4'h0 : h_reg.div + 4'h1;
    case (h_reg.st)
      ccr_pkg::CCR_H_IDLE: begin
        h_next.sclk = 1'b0;
        h_next.fsync = 1'b0;
        if (acc && pwrite && paddr == `CCR_APB_CMD) begin
          // Bits 15:14 are forced low; reserved data bits are left to software.
          h_next.shout = {2'b00, pwdata[13:0]};
          h_next.bits = 5'h00;
          h_next.done = 1'b0;
          h_next.st = ccr_pkg::CCR_H_SHIFT;
        end
      end
      ccr_pkg::CCR_H_SHIFT: begin
        if (tick) begin
          h_next.sclk = ~h_reg.sclk;
          if (!h_reg.sclk) begin
            h_next.fsync = (h_reg.bits == 5'h00);
          end else begin
            h_next.shout = {h_reg.shout[14:0], 1'b0};
            h_next.shin = {h_reg.shin[14:0], h_reg.din_s[1]};
            h_next.bits = h_reg.bits + 5'h01;
            // Extra bit clocks would shift the answer out of the receive register.
            if (h_reg.bits == 5'(`CCR_WORD_BITS - 1)) begin
              h_next.st = ccr_pkg::CCR_H_DONE;
            end
          end
        end
      end
      ccr_pkg::CCR_H_DONE: begin
        h_next.rdata = h_reg.shin[7:0];
        h_next.done = 1'b1;
        h_next.st = ccr_pkg::CCR_H_IDLE;
      end
      default: h_next.st = ccr_pkg::CCR_H_IDLE;
    endcase
    if (psel && !penable && !pwrite) begin
      if (paddr == `CCR_APB_STAT) begin
        h_next.prdata = {30'h00000000, h_reg.done, h_reg.st != ccr_pkg::CCR_H_IDLE};
      end else if (paddr == `CCR_APB_RDATA) begin
        h_next.prdata = {24'h000000, h_reg.rdata};
      end else begin
        h_next.prdata = 32'h00000000;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      h_reg <= '0;
    end else begin
      h_reg <= h_next;
    end
  end

  // Read data is registered in the setup cycle, so every access completes without a wait cycle.
  assign pready = psel & penable;
  assign prdata = h_reg.prdata;
  assign pslverr = 1'b0;
  assign link.bit_clk = h_reg.sclk;
  assign link.frame_sync_in = h_reg.fsync;
  assign link.host_dout = h_reg.shout[15];
endmodule

// ### verif/ccr_assertions.sv
// Checker on the link wires between host port and register bank.
// Assumes the host makes bit clock and frame strobe on the system clock.
`timescale 1ns/1ns
module ccr_assertions (
  // System.
  input wire logic clk,
  input wire logic rst,
  // Link.
  input wire logic bit_clk,
  input wire logic frame_sync_in,
  input wire logic host_dout,
  input wire logic dev_dout
);
  logic       bc_q;
  logic [4:0] rise_cnt;
  // Counting rises, not cycles, keeps the frame check free of the clock ratio.
  always_ff @(posedge clk) begin
    if (rst) begin
      bc_q     <= 1'b0;
      rise_cnt <= 5'h00;
    end else begin
      bc_q     <= bit_clk;
      if (bit_clk && !bc_q) begin
        rise_cnt <= frame_sync_in ? 5'h01 : rise_cnt + 5'h01;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  AST_RST_IDLE: assert property ($fell(rst) |-> !bit_clk && !frame_sync_in && !host_dout)
    else $error("link not idle after reset");
  AST_CLK_HIGH: assert property ($rose(bit_clk) |-> bit_clk [*4] ##1 !bit_clk)
    else $error("bit clock high phase wrong");
  AST_CLK_LOW: assert property ($fell(bit_clk) |-> !bit_clk [*4])
    else $error("bit clock low phase short");
  AST_SYNC_ONEBIT: assert property ($rose(frame_sync_in) |-> ##[1:16] !frame_sync_in)
    else $error("frame strobe too long");
  AST_SYNC_ALIGN: assert property ($rose(frame_sync_in) |-> ##[0:8] (bit_clk && !bc_q))
    else $error("frame strobe without bit clock");
  AST_HOST_STABLE: assert property (bit_clk && bc_q |-> $stable(host_dout))
    else $error("host data moved while sampled");
  AST_FRAME_LEN: assert property (frame_sync_in && bit_clk && !bc_q |-> rise_cnt == 5'h00 || rise_cnt == 5'h10)
    else $error("frame not 16 bits");
  AST_FRAME_MAX: assert property (bit_clk && !bc_q && !frame_sync_in |-> rise_cnt inside {[5'h01:5'h0F]})
    else $error("bit outside frame");
endmodule

// ### verif/codec_control_registers_tb_top.sv
// Bench: APB host port and register bank joined over the link, checked at the decoded outputs.
// Assumes zero-wait APB with registered read data and read data returned in the next frame.
`timescale 1ns/1ns
`include "ccr_regs.svh"
module codec_control_registers_tb_top;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, fir_overflow;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        soft_reset, power_down, adc_aux_sel, mon_aux_sel, digital_loopback, dac_16bit, sw_secondary_req;
  logic        flag_out, phone_mode, adc_16bit, analog_loopback, sync_delay_en, sync_delay_low;
  logic        pll_bypass, slot_active;
  ccr_pkg::ccr_mon_gain_t mon_gain;
  logic [5:0]  sync_delay_bits;
  logic [1:0]  slave_count, in_gain, out_gain;
  logic [3:0]  rate_divisor;
  logic [7:0]  d;
  logic [31:0] q;
  int          failures, n_compared, pulses;
  ccr_link_if ccr_link_if_i ();
  ccr_host ccr_host_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(ccr_link_if_i));
  ccr_device ccr_device_i (.clk(clk), .rst(rst), .link(ccr_link_if_i), .fir_overflow(fir_overflow),
    .soft_reset(soft_reset), .power_down(power_down), .adc_aux_sel(adc_aux_sel), .mon_aux_sel(mon_aux_sel),
    .mon_gain(mon_gain), .digital_loopback(digital_loopback), .dac_16bit(dac_16bit),
    .sw_secondary_req(sw_secondary_req), .flag_out(flag_out), .phone_mode(phone_mode), .adc_16bit(adc_16bit),
    .analog_loopback(analog_loopback), .sync_delay_en(sync_delay_en), .sync_delay_bits(sync_delay_bits),
    .sync_delay_low(sync_delay_low), .slave_count(slave_count), .in_gain(in_gain), .out_gain(out_gain),
    .rate_divisor(rate_divisor), .pll_bypass(pll_bypass), .slot_active(slot_active));
  ccr_assertions ccr_assertions_i (.clk(clk), .rst(rst), .bit_clk(ccr_link_if_i.bit_clk),
    .frame_sync_in(ccr_link_if_i.frame_sync_in), .host_dout(ccr_link_if_i.host_dout),
    .dev_dout(ccr_link_if_i.dev_dout));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    if (soft_reset === 1'b1) pulses++;
  end
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd_q);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd_q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Read data stands in the access phase, so one access suffices.
  task automatic rd(input logic [11:0] a, output logic [31:0] rd_q);
    apb(1'b0, a, 32'h00000000, rd_q);
  endtask
  task automatic send(input logic [13:0] w);
    logic [31:0] s;
    apb(1'b1, `CCR_APB_CMD, {18'h00000, w}, s);
    s = 32'h00000001;
    while (s[0] !== 1'b0) rd(`CCR_APB_STAT, s);
    repeat (6) @(posedge clk);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    send({1'b0, a, v});
  endtask
  task automatic rdreg(input logic [4:0] a, input logic [7:0] e);
    logic [31:0] s;
    send({1'b1, a, 8'h00});
    send(14'h0000);
    rd(`CCR_APB_RDATA, s);
    check("readback", s[7:0], e);
  endtask
  task automatic tally_and_finish;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    tally_and_finish();
  end
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    fir_overflow = 1'b0;
    failures = 0;
    n_compared = 0;
    pulses = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check("reset", {power_down, rate_divisor, sync_delay_en, sw_secondary_req, mon_gain, in_gain, slot_active},
      12'h460);
    for (int i = 0; i < 4; i++) begin
      d = {1'b0, i[0], i[1], i[0], i[1:0], i[1], i[0]};
      wr(5'h01, d);
      check("ctrl1", {power_down, adc_aux_sel, mon_aux_sel, mon_gain, digital_loopback, dac_16bit, sw_secondary_req},
        {d[6:0], ~d[0]});
    end
    rdreg(5'h01, d);
    wr(5'h04, 8'h35);
    pulses = 0;
    wr(5'h01, 8'h80);
    check("pulses", pulses, 1);
    check("restored", rate_divisor, 4'h8);
    rdreg(5'h01, 8'h00);
    wr(5'h02, 8'hFC);
    check("ctrl2", {flag_out, phone_mode, adc_16bit, analog_loopback, sync_delay_en}, 5'h1E);
    rdreg(5'h02, 8'hDC);
    fir_overflow <= 1'b1;
    @(posedge clk);
    fir_overflow <= 1'b0;
    rdreg(5'h02, 8'hFC);
    wr(5'h04, 8'h00);
    wr(5'h03, 8'h52);
    check("ctrl3", {slave_count, sync_delay_bits, sync_delay_low, slot_active}, 10'h149);
    wr(5'h03, 8'hD1);
    check("low", {slave_count, sync_delay_bits, sync_delay_low}, 9'h1A3);
    for (int n = 0; n < 8; n++) begin
      d = {n[0], n[2:0], n[1], n[2], ~n[0], n[1]};
      wr(5'h04, d);
      check("ctrl4", {pll_bypass, rate_divisor, in_gain, out_gain},
        {d[7], (d[6:4] == 3'h0) ? 4'h8 : {1'b0, d[6:4]}, d[3:0]});
    end
    wr(5'h00, 8'hFF);
    wr(5'h05, 8'hFF);
    rdreg(5'h04, d);
    apb(1'b1, `CCR_APB_CMD, {18'h00000, 1'b0, 5'h04, 8'h00}, q);
    send({1'b0, 5'h01, 8'h7F});
    rdreg(5'h04, 8'h00);
    rdreg(5'h01, 8'h00);
    apb(1'b0, 12'h00C, 32'h00000000, q);
    check("slverr", pslverr, 1'b0);
    tally_and_finish();
  end
endmodule
